//--- verilog/dasb_map.svh
// Purpose: Register map, reset values and field positions of the diagnostic
//          and conversion status bank.
// Assumes: APB with 32-bit data; one register per aligned word.
// Notes:   Offsets below are register indices; byte address is four times
//          the index.
`ifndef DASB_MAP_SVH
`define DASB_MAP_SVH

// Register indices.
`define DASB_IDX_SUPPLY      10'h072
`define DASB_IDX_CONV        10'h073
`define DASB_IDX_FAULT_LO    10'h074
`define DASB_IDX_FAULT_HI    10'h075
`define DASB_IDX_MEM_REF     10'h077
`define DASB_IDX_IRQ_STATUS  10'h080
`define DASB_IDX_IRQ_MASK    10'h081

// Reset values.
`define DASB_RST_SUPPLY      8'h00
`define DASB_RST_CONV        8'h00
`define DASB_RST_MEM_REF     8'hef
`define DASB_RST_IRQ_MASK    3'h0

// Interrupt status and mask bit positions.
`define DASB_IRQ_CONV        0
`define DASB_IRQ_SUPPLY      1
`define DASB_IRQ_FAULT       2
`define DASB_IRQ_W           3

// Fault channels held in the low register, and the most channels the bank holds.
`define DASB_LO_CH           8
`define DASB_MAX_CH          16

`endif

//--- verilog/dasb_pkg.sv
// Purpose: Types shared by the status bank modules.
// Assumes: Constants come from dasb_map.svh.
// Notes:   Each module keeps all of its state in one packed struct.
`include "dasb_map.svh"

package dasb_pkg;

  typedef logic [7:0] dasb_byte_t;

  // State of the fault flag bank.
  typedef struct packed {
    logic [`DASB_MAX_CH-1:0] flags;
  } dasb_fault_s;

  // State of the register bank and bus slave.
  typedef struct packed {
    dasb_byte_t                supply;
    dasb_byte_t                conv;
    logic                      conv_done;
    dasb_byte_t                mem_ref;
    logic [`DASB_IRQ_W-1:0]    irq_stat;
    logic [`DASB_IRQ_W-1:0]    irq_mask;
    logic                      irq;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
  } dasb_regs_s;

endpackage

//--- verilog/dasb_fault_bank.sv
// Purpose: Per-channel on-demand diagnostic fault flags.
// Assumes: Engine pulses diag_done with the fault vector valid in that cycle.
// Notes:   Flags are sticky until the next diagnostic run starts.
`timescale 1ns/1ps
`include "dasb_map.svh"

module dasb_fault_bank
  import dasb_pkg::*;
#(
  parameter int CHANNELS = 12
) (
  // Clock and reset.
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Diagnostic engine.
  input  wire logic                diag_start,
  input  wire logic                diag_done,
  input  wire logic [CHANNELS-1:0] diag_fault,
  // Flag view.
  output logic [CHANNELS-1:0]      fault_flags
);

  dasb_fault_s state_reg;
  dasb_fault_s state_next;
  logic [`DASB_MAX_CH-1:0] flag_nxt;

  // Refuse widths that do not fit the two flag registers.
  if (CHANNELS <= `DASB_LO_CH || CHANNELS > `DASB_MAX_CH) begin : g_bad
    $error("CHANNELS must be 9 to 16");
  end

  // One flag per channel; a fault reported in the start cycle still sets.
  for (genvar i = 0; i < `DASB_MAX_CH; i++) begin : g_ch
    if (i < CHANNELS) begin : g_used
      assign flag_nxt[i] = (diag_done && diag_fault[i]) ? 1'b1 :
                           diag_start ? 1'b0 : state_reg.flags[i];
    end else begin : g_unused
      assign flag_nxt[i] = 1'b0;
    end
  end

  // Next state copy.
  always_comb begin
    state_next       = state_reg;
    state_next.flags = flag_nxt;
  end

  // State register; no fault is reported after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign fault_flags = state_reg.flags[CHANNELS-1:0];

endmodule

//--- verilog/dasb_status_bank.sv
// Purpose: Read-only status bank with conversion results, on-demand fault
//          flags, memory-check reference and an interrupt block on APB.
// Assumes: All inputs are synchronous to pclk; APB master per AMBA APB.
// Notes:   Every access answers in one wait-free access cycle.
`timescale 1ns/1ps
`include "dasb_map.svh"

module dasb_status_bank
  import dasb_pkg::*;
#(
  parameter int ADDR_W   = 12,
  parameter int CHANNELS = 12
) (
  // Clock and reset.
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave.
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Converter results.
  input  wire logic                supply_valid,
  input  wire logic [7:0]          supply_data,
  input  wire logic                conv_valid,
  input  wire logic [7:0]          conv_data,
  // On-demand diagnostic engine.
  input  wire logic                diag_start,
  input  wire logic                diag_done,
  input  wire logic [CHANNELS-1:0] diag_fault,
  // Memory-check reference update from the programming sequence.
  input  wire logic                mem_ref_load,
  input  wire logic [7:0]          mem_ref_data,
  // Status outputs.
  output logic                     conversion_complete_flag,
  output logic                     irq
);

  dasb_regs_s            state_reg;
  dasb_regs_s            state_next;
  logic [CHANNELS-1:0]   fault_flags;
  logic [`DASB_MAX_CH-1:0] fault_wide;
  logic [9:0]            idx;
  logic                  setup;
  logic                  done;
  logic                  wr_done;
  logic                  rd_done;
  logic                  hit;
  logic [31:0]           rd_val;
  logic [`DASB_IRQ_W-1:0] evt;
  logic [`DASB_IRQ_W-1:0] w1c;

  // The index decode needs ten address bits above the byte lanes.
  if (ADDR_W < 12) begin : g_bad_addr
    $error("ADDR_W must be at least 12");
  end

  // The high flag register shows only four channels, so more would be lost.
  if (CHANNELS <= `DASB_LO_CH || CHANNELS > 12) begin : g_bad_ch
    $error("CHANNELS must be 9 to 12");
  end

  // Per-channel fault flags live in their own bank.
  dasb_fault_bank #(
    .CHANNELS (CHANNELS)
  ) u_fault (
    .pclk        (pclk),
    .presetn     (presetn),
    .diag_start  (diag_start),
    .diag_done   (diag_done),
    .diag_fault  (diag_fault),
    .fault_flags (fault_flags)
  );

  // Unused upper channels read as zero.
  always_comb begin
    fault_wide                 = '0;
    fault_wide[CHANNELS-1:0]   = fault_flags;
  end

  // Bus phase decode. Only the word index matters; byte lanes are ignored
  // because no register here takes written data except the interrupt block.
  assign idx     = paddr[11:2];
  assign setup   = psel && !penable;
  assign done    = psel && penable && state_reg.pready;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;

  // Read multiplexer and map hit. Unmapped words read zero and error.
  always_comb begin
    rd_val = 32'h0000_0000;
    hit    = 1'b1;
    case (idx)
      `DASB_IDX_SUPPLY: begin
        rd_val[7:0] = state_reg.supply;
      end
      `DASB_IDX_CONV: begin
        rd_val[7:0] = state_reg.conv;
      end
      `DASB_IDX_FAULT_LO: begin
        rd_val[7:0] = fault_wide[7:0];
      end
      `DASB_IDX_FAULT_HI: begin
        rd_val[3:0] = fault_wide[11:8];
      end
      `DASB_IDX_MEM_REF: begin
        rd_val[7:0] = state_reg.mem_ref;
      end
      `DASB_IDX_IRQ_STATUS: begin
        rd_val[`DASB_IRQ_W-1:0] = state_reg.irq_stat;
      end
      `DASB_IDX_IRQ_MASK: begin
        rd_val[`DASB_IRQ_W-1:0] = state_reg.irq_mask;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Interrupt events: new conversion data, new supply data, and a
  // diagnostic run that reported at least one faulty channel.
  always_comb begin
    evt                   = '0;
    evt[`DASB_IRQ_CONV]   = conv_valid;
    evt[`DASB_IRQ_SUPPLY] = supply_valid;
    evt[`DASB_IRQ_FAULT]  = diag_done && (|diag_fault);
  end

  // Write-one-to-clear mask for the interrupt status, only on lane 0.
  always_comb begin
    w1c = '0;
    if (wr_done && idx == `DASB_IDX_IRQ_STATUS && pstrb[0]) begin
      w1c = pwdata[`DASB_IRQ_W-1:0];
    end
  end

  // Next-state logic for all registers.
  always_comb begin
    state_next = state_reg;

    // Converter results follow the engine; the bus cannot write them.
    if (supply_valid) begin
      state_next.supply = supply_data;
    end
    if (conv_valid) begin
      state_next.conv = conv_data;
    end

    // The completion flag clears when the result register is read; fresh
    // data landing in that same cycle keeps it set, but a result landing in the setup cycle is cleared unread.
    if (conv_valid) begin
      state_next.conv_done = 1'b1;
    end else if (rd_done && hit && idx == `DASB_IDX_CONV) begin
      state_next.conv_done = 1'b0;
    end

    // Reference changes only through the programming sequence.
    if (mem_ref_load) begin
      state_next.mem_ref = mem_ref_data;
    end

    // Sticky status: set wins over a software clear in the same cycle.
    state_next.irq_stat = (state_reg.irq_stat & ~w1c) | evt;

    // Mask register write; other writes are dropped, except the write-one-to-clear of the interrupt status.
    if (wr_done && idx == `DASB_IDX_IRQ_MASK && pstrb[0]) begin
      state_next.irq_mask = pwdata[`DASB_IRQ_W-1:0];
    end

    // Level interrupt while any unmasked status bit is set.
    state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

    // Answer in the first access cycle: data and error are prepared in the
    // setup cycle, so prdata may lag a result that lands one cycle later.
    state_next.pready = 1'b0;
    if (setup) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !hit;
      state_next.prdata  = pwrite ? 32'h0000_0000 : rd_val;
    end else if (done) begin
      state_next.pslverr = 1'b0;
      state_next.prdata  = 32'h0000_0000;
    end
  end

  // State register with documented reset values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg           <= '0;
      state_reg.supply    <= `DASB_RST_SUPPLY;
      state_reg.conv      <= `DASB_RST_CONV;
      state_reg.mem_ref   <= `DASB_RST_MEM_REF;
      state_reg.irq_mask  <= `DASB_RST_IRQ_MASK;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register.
  assign pready                   = state_reg.pready;
  assign prdata                   = state_reg.prdata;
  assign pslverr                  = state_reg.pslverr;
  assign irq                      = state_reg.irq;
  assign conversion_complete_flag = state_reg.conv_done;

endmodule

//--- dv/dasb_status_bank_asserts.sv
// Purpose: Port-level checks of the status bank.
// Assumes: One pclk domain; presetn asynchronous, active low.
// Notes:   Read data is checked while the address still holds in the access.
`timescale 1ns/1ps
`include "dasb_map.svh"
module dasb_status_bank_asserts #(
  parameter int ADDR_W = 12
) (
  // Clock, reset and bus.
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // Conversion status.
  input wire logic              conv_valid,
  input wire logic              conversion_complete_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decoded reads; a completing read of the result is what clears the flag.
  wire rd    = pready && !pwrite;
  wire rd_cv = psel && penable && rd && paddr[11:2] == `DASB_IDX_CONV;
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error out of step");
  property p_set; conv_valid |=> conversion_complete_flag; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_clr; rd_cv && !conv_valid |=> !conversion_complete_flag; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_hold; !conv_valid && !rd_cv |=> $stable(conversion_complete_flag); endproperty
  a_hold: assert property (p_hold) else $error("flag moved");
  property p_lo; rd && paddr[11:2] == `DASB_IDX_FAULT_LO |-> prdata[31:8] == 24'h0; endproperty
  a_lo: assert property (p_lo) else $error("fault low wide");
  property p_hi; rd && paddr[11:2] == `DASB_IDX_FAULT_HI |-> prdata[31:4] == 28'h0; endproperty
  a_hi: assert property (p_hi) else $error("reserved bits set");
  property p_ref; rd && paddr[11:2] == `DASB_IDX_MEM_REF |-> prdata[31:8] == 24'h0; endproperty
  a_ref: assert property (p_ref) else $error("reference wide");
endmodule
bind dasb_status_bank dasb_status_bank_asserts #(
  .ADDR_W (ADDR_W)
) u_chk (
  .pclk                     (pclk),
  .presetn                  (presetn),
  .psel                     (psel),
  .penable                  (penable),
  .pwrite                   (pwrite),
  .paddr                    (paddr),
  .pready                   (pready),
  .prdata                   (prdata),
  .pslverr                  (pslverr),
  .conv_valid               (conv_valid),
  .conversion_complete_flag (conversion_complete_flag)
);

//--- dv/dasb_status_bank_tb.sv
// Purpose: Directed bus-level test of the status bank.
// Assumes: One idle cycle between bus transfers is enough for every check.
// Notes:   Bus answers are taken at the rising edge that sees pready high;
//          level outputs are sampled on the falling edge, where they settle.
`timescale 1ns/1ps
`include "dasb_map.svh"
module dasb_status_bank_tb;
  // Stimulus and observed signals, named as the ports they drive or watch; rdat and rerr keep the last bus answer.
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        supply_valid = 0, conv_valid = 0, diag_start = 0, diag_done = 0;
  logic        mem_ref_load = 0, pready, pslverr, conversion_complete_flag, irq, rerr;
  logic [11:0] paddr = 0, diag_fault = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [7:0]  supply_data = 0, conv_data = 0, mem_ref_data = 0;
  logic [3:0]  pstrb = 4'hf;
  int          bad_count = 0, comparisons = 0;
  dasb_status_bank dut (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .pstrb                    (pstrb),
    .pready                   (pready),
    .prdata                   (prdata),
    .pslverr                  (pslverr),
    .supply_valid             (supply_valid),
    .supply_data              (supply_data),
    .conv_valid               (conv_valid),
    .conv_data                (conv_data),
    .diag_start               (diag_start),
    .diag_done                (diag_done),
    .diag_fault               (diag_fault),
    .mem_ref_load             (mem_ref_load),
    .mem_ref_data             (mem_ref_data),
    .conversion_complete_flag (conversion_complete_flag),
    .irq                      (irq)
  );
  // Free-running bus clock.
  always #10 pclk = ~pclk;
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus transfer; it waits for pready under a bound and keeps the request until then.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    bit ok;
    ok = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    // The answer is read at the rising edge, before that edge's updates land.
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    if (!ok) begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic rc(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    apb(0, idx, 32'h0);
    chk(nm, rdat, exp);
  endtask
  // Main sequence: reset values, loads, read side effects, refusals, interrupt.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rc("conv", `DASB_IDX_CONV, 32'h0);
    rc("fault lo", `DASB_IDX_FAULT_LO, 32'h0);
    rc("fault hi", `DASB_IDX_FAULT_HI, 32'h0);
    rc("ref", `DASB_IDX_MEM_REF, 32'hef);
    $display("test reset done");
    @(posedge pclk);
    conv_valid <= 1;
    conv_data <= 8'h5a;
    supply_valid <= 1;
    supply_data <= 8'ha5;
    diag_done <= 1;
    diag_fault <= 12'h96c;
    @(posedge pclk);
    conv_valid <= 0;
    supply_valid <= 0;
    diag_done <= 0;
    @(negedge pclk);
    chk("flag", {31'h0, conversion_complete_flag}, 32'h1);
    rc("supply", `DASB_IDX_SUPPLY, 32'ha5);
    @(negedge pclk);
    chk("flag", {31'h0, conversion_complete_flag}, 32'h1);
    rc("conv", `DASB_IDX_CONV, 32'h5a);
    @(negedge pclk);
    chk("flag", {31'h0, conversion_complete_flag}, 32'h0);
    rc("fault lo", `DASB_IDX_FAULT_LO, 32'h6c);
    rc("fault hi", `DASB_IDX_FAULT_HI, 32'h09);
    $display("test loads done");
    // Writes to status places are dropped; an unmapped place answers with an error.
    apb(1, `DASB_IDX_CONV, 32'hffffffff);
    apb(1, `DASB_IDX_FAULT_LO, 32'hffffffff);
    apb(1, `DASB_IDX_MEM_REF, 32'h0);
    rc("conv", `DASB_IDX_CONV, 32'h5a);
    rc("fault lo", `DASB_IDX_FAULT_LO, 32'h6c);
    rc("ref", `DASB_IDX_MEM_REF, 32'hef);
    rc("unmapped", 10'h0fc, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    @(posedge pclk);
    mem_ref_load <= 1;
    mem_ref_data <= 8'h3c;
    diag_start <= 1;
    @(posedge pclk);
    mem_ref_load <= 0;
    diag_start <= 0;
    rc("ref", `DASB_IDX_MEM_REF, 32'h3c);
    rc("fault lo", `DASB_IDX_FAULT_LO, 32'h0);
    $display("test refusals done");
    // Interrupt: unmask the fault event, mask it again, then clear it.
    apb(1, `DASB_IDX_IRQ_MASK, 32'h4);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1, `DASB_IDX_IRQ_MASK, 32'h0);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1, `DASB_IDX_IRQ_MASK, 32'h4);
    apb(1, `DASB_IDX_IRQ_STATUS, 32'h4);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, 32'h0);
    rc("status", `DASB_IDX_IRQ_STATUS, 32'h3);
    // A write without byte lane 0 must leave the mask as it is.
    pstrb <= 4'he;
    apb(1, `DASB_IDX_IRQ_MASK, 32'h0);
    pstrb <= 4'hf;
    rc("mask", `DASB_IDX_IRQ_MASK, 32'h4);
    $display("test interrupt done");
    stop_test();
  end
endmodule
